// *** hw/serial_eeprom_rw_engine.sv ***
// two-wire serial eeprom command engine with page buffer and self-timed programming
`default_nettype none
// Operation
// - a 13-bit word address selects one array byte
// - byte write: ack both address bytes and the data byte
// - stop after write starts timed programming; bus ignored until done
// - up to 32 bytes per cycle within one row
// - page write: every received data byte is acknowledged
// - write data advances only low five address bits, wrapping in page
// - no device address ack while programming; ack at once afterwards
// - protect input high blocks all array writes
// - protect input sampled at the stop ending a write
// - protected write: ack all bytes, no programming, ready at once
// - address counter holds last accessed address plus one
// - read past last byte wraps to first array byte
// - read with no word address returns byte at counter
// - host nack in ninth clock ends the read
// - acked reads keep incrementing and output next byte
// - delivered array reads ffh everywhere
// - ack address only on type nibble and strap match
// - address 12..8 from first byte bits 4..0, 7..0 from second
module serial_eeprom_rw_engine #(
  parameter logic [eeprom_pkg::PROG_CNT_W-1:0] PROG_CYCLES = eeprom_pkg::PROG_CYCLES_DEF,
  parameter logic [3:0] DEV_TYPE = eeprom_pkg::DEV_TYPE_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_wp,
  input wire logic i_strap_addr_bit2,
  input wire logic i_strap_addr_bit1,
  input wire logic i_strap_addr_bit0,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_prog_busy
);
  // ****************************************
  // reset release and pin sampling
  // ****************************************
  logic rst_meta_reg;
  logic rst_sync_reg;
  eeprom_pkg::pin_in_t pins_raw;
  eeprom_pkg::pin_in_t pins_s;
  logic scl_q_reg;
  logic sda_q_reg;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign pins_raw.scl = i_scl;
  assign pins_raw.sda = i_sda;
  assign pins_raw.wp = i_wp;
  assign pins_raw.strap = {i_strap_addr_bit2, i_strap_addr_bit1, i_strap_addr_bit0};

  pin_sync u_pin_sync (
    .i_clk(i_clk),
    .i_rst_b(rst_sync_reg),
    .i_pins(pins_raw),
    .o_pins(pins_s)
  );

  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= pins_s.scl;
      sda_q_reg <= pins_s.sda;
    end
  end

  // ****************************************
  // bus events
  // ****************************************
  eeprom_pkg::state_t state_reg;
  eeprom_pkg::state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic ack_phase_reg;
  logic ack_phase_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic host_ack_reg;
  logic busy_reg;
  logic [eeprom_pkg::PROG_CNT_W-1:0] prog_cnt_reg;
  logic [eeprom_pkg::ADDR_W-1:0] addr_reg;
  logic [eeprom_pkg::PAGE_W-1:0] addr_hi_reg;
  logic [eeprom_pkg::PAGE_BYTES-1:0] flags_reg;
  logic [7:0] page_buf [eeprom_pkg::PAGE_BYTES];
  logic [7:0] mem_array [eeprom_pkg::MEM_BYTES] = '{default: eeprom_pkg::ERASED_BYTE};

  wire logic scl_rise = pins_s.scl & ~scl_q_reg;
  wire logic scl_fall = ~pins_s.scl & scl_q_reg;
  wire logic start_evt = pins_s.scl & scl_q_reg & sda_q_reg & ~pins_s.sda;
  wire logic stop_evt = pins_s.scl & scl_q_reg & ~sda_q_reg & pins_s.sda;
  wire logic active = (state_reg != eeprom_pkg::st_idle) & ~busy_reg;
  wire logic byte_done = active & scl_fall & (cnt_reg == eeprom_pkg::BIT_LAST) & ~ack_phase_reg;
  wire logic ack_end = active & scl_fall & ack_phase_reg;
  wire logic bit_rise = active & scl_rise & (cnt_reg != eeprom_pkg::BIT_LAST);
  wire logic rd_bit_fall = active & scl_fall & ~ack_phase_reg & (state_reg == eeprom_pkg::st_read)
    & (cnt_reg != eeprom_pkg::BIT_LAST);
  wire logic [2:0] bit_sel = 3'(eeprom_pkg::BIT_MSB - cnt_reg);
  wire logic type_ok = shift_reg[7:4] == DEV_TYPE;
  wire logic strap_ok = shift_reg[3:1] == pins_s.strap;
  wire logic dev_match = type_ok & strap_ok & ~busy_reg;
  wire logic rw_bit = shift_reg[0];
  wire logic host_acks = active & scl_rise & ack_phase_reg & (state_reg == eeprom_pkg::st_read)
    & ~pins_s.sda;
  wire logic rd_first = byte_done & (state_reg == eeprom_pkg::st_dev) & dev_match & rw_bit;
  wire logic tx_load = rd_first | host_acks;
  wire logic wdata_done = byte_done & (state_reg == eeprom_pkg::st_wdata);
  wire logic have_data = |flags_reg;
  wire logic write_stop = stop_evt & ~busy_reg & (state_reg == eeprom_pkg::st_wdata) & have_data;
  wire logic start_prog = write_stop & ~pins_s.wp;
  wire logic prog_done = busy_reg & (prog_cnt_reg == PROG_CYCLES - eeprom_pkg::PROG_ONE);
  wire logic [eeprom_pkg::PAGE_W-1:0] slot = prog_cnt_reg[eeprom_pkg::PAGE_W-1:0];
  wire logic commit_en = busy_reg & (prog_cnt_reg < eeprom_pkg::PAGE_SLOTS) & flags_reg[slot];
  wire logic [eeprom_pkg::ADDR_W-1:0] commit_addr = {addr_reg[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W],
    slot};
  wire logic [eeprom_pkg::PAGE_W-1:0] page_next = addr_reg[eeprom_pkg::PAGE_W-1:0] + 5'h01;

  // ****************************************
  // protocol sequencer
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ack_phase_next = ack_phase_reg;
    sda_oe_next = sda_oe_reg;
    if (busy_reg) begin
      state_next = eeprom_pkg::st_idle;
      cnt_next = 4'h0;
      ack_phase_next = 1'b0;
      sda_oe_next = 1'b0;
    end else if (start_evt) begin
      state_next = eeprom_pkg::st_dev;
      cnt_next = 4'h0;
      ack_phase_next = 1'b0;
      sda_oe_next = 1'b0;
    end else if (stop_evt) begin
      state_next = eeprom_pkg::st_idle;
      sda_oe_next = 1'b0;
    end else if (active) begin
      if (bit_rise) begin
        cnt_next = cnt_reg + 4'h1;
      end
      if (byte_done) begin
        ack_phase_next = 1'b1;
        case (state_reg)
          eeprom_pkg::st_dev: begin
            if (dev_match) begin
              sda_oe_next = 1'b1;
            end else begin
              state_next = eeprom_pkg::st_idle;
              sda_oe_next = 1'b0;
            end
          end
          eeprom_pkg::st_waddr_hi: sda_oe_next = 1'b1;
          eeprom_pkg::st_waddr_lo: sda_oe_next = 1'b1;
          eeprom_pkg::st_wdata: sda_oe_next = 1'b1;
          eeprom_pkg::st_read: sda_oe_next = 1'b0;
          default: sda_oe_next = 1'b0;
        endcase
      end else if (ack_end) begin
        ack_phase_next = 1'b0;
        cnt_next = 4'h0;
        sda_oe_next = 1'b0;
        case (state_reg)
          eeprom_pkg::st_dev: begin
            if (rw_bit) begin
              state_next = eeprom_pkg::st_read;
              sda_oe_next = ~tx_reg[eeprom_pkg::BYTE_W-1];
            end else begin
              state_next = eeprom_pkg::st_waddr_hi;
            end
          end
          eeprom_pkg::st_waddr_hi: state_next = eeprom_pkg::st_waddr_lo;
          eeprom_pkg::st_waddr_lo: state_next = eeprom_pkg::st_wdata;
          eeprom_pkg::st_wdata: state_next = eeprom_pkg::st_wdata;
          eeprom_pkg::st_read: begin
            if (host_ack_reg) begin
              sda_oe_next = ~tx_reg[eeprom_pkg::BYTE_W-1];
            end else begin
              state_next = eeprom_pkg::st_idle;
            end
          end
          default: state_next = eeprom_pkg::st_idle;
        endcase
      end else if (rd_bit_fall) begin
        sda_oe_next = ~tx_reg[bit_sel];
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= eeprom_pkg::st_idle;
      cnt_reg <= 4'h0;
      ack_phase_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ack_phase_reg <= ack_phase_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // ****************************************
  // shift register and host acknowledge
  // ****************************************
  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      shift_reg <= 8'h00;
      host_ack_reg <= 1'b0;
    end else begin
      if (bit_rise) begin
        shift_reg <= {shift_reg[6:0], pins_s.sda};
      end
      if (active & scl_rise & ack_phase_reg) begin
        host_ack_reg <= ~pins_s.sda;
      end
    end
  end

  // ****************************************
  // word address counter
  // ****************************************
  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      addr_reg <= '0;
      addr_hi_reg <= '0;
    end else if (byte_done & (state_reg == eeprom_pkg::st_waddr_hi)) begin
      addr_hi_reg <= shift_reg[eeprom_pkg::PAGE_W-1:0];
    end else if (byte_done & (state_reg == eeprom_pkg::st_waddr_lo)) begin
      addr_reg <= {addr_hi_reg, shift_reg};
    end else if (wdata_done) begin
      addr_reg[eeprom_pkg::PAGE_W-1:0] <= page_next;
    end else if (tx_load) begin
      addr_reg <= addr_reg + 13'h0001;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      tx_reg <= eeprom_pkg::ERASED_BYTE;
    end else if (tx_load) begin
      tx_reg <= mem_array[addr_reg];
    end
  end

  // ****************************************
  // page buffer
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (wdata_done) begin
      page_buf[addr_reg[eeprom_pkg::PAGE_W-1:0]] <= shift_reg;
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      flags_reg <= '0;
    end else if (prog_done | (write_stop & pins_s.wp)) begin
      flags_reg <= '0;
    end else if (start_evt & ~busy_reg) begin
      flags_reg <= '0;
    end else if (wdata_done) begin
      flags_reg[addr_reg[eeprom_pkg::PAGE_W-1:0]] <= 1'b1;
    end
  end

  // ****************************************
  // self-timed programming
  // ****************************************
  always_ff @(posedge i_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
    end else if (start_prog) begin
      busy_reg <= 1'b1;
      prog_cnt_reg <= '0;
    end else if (prog_done) begin
      busy_reg <= 1'b0;
      prog_cnt_reg <= '0;
    end else if (busy_reg) begin
      prog_cnt_reg <= prog_cnt_reg + eeprom_pkg::PROG_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (commit_en) begin
      mem_array[commit_addr] <= page_buf[slot];
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_oe_reg;
  assign o_prog_busy = busy_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_sync_reg);

  a_quiet_while_busy: assert property (busy_reg |=> !sda_oe_reg)
    else $error("sda driven during programming");
  a_prog_on_stop: assert property (start_prog |=> busy_reg && prog_cnt_reg == '0)
    else $error("programming not started at stop");
  a_protect_blocks: assert property (write_stop && pins_s.wp |=> !busy_reg)
    else $error("protected write started programming");
  a_page_wraps: assert property (wdata_done |=> addr_reg[12:5] == $past(addr_reg[12:5])
    && addr_reg[4:0] == $past(addr_reg[4:0]) + 5'h01)
    else $error("page write address step wrong");
  a_read_advance: assert property (tx_load |=> addr_reg == $past(addr_reg) + 13'h0001
    && tx_reg == mem_array[$past(addr_reg)])
    else $error("read address or data wrong");
  a_addr_load: assert property (byte_done && state_reg == eeprom_pkg::st_waddr_lo
    |=> addr_reg == {$past(addr_hi_reg), $past(shift_reg)})
    else $error("word address not loaded");
  a_dev_nomatch: assert property (byte_done && state_reg == eeprom_pkg::st_dev && !dev_match
    |=> !sda_oe_reg && state_reg == eeprom_pkg::st_idle)
    else $error("foreign address acknowledged");
  a_write_ack: assert property (byte_done && state_reg inside {eeprom_pkg::st_waddr_hi,
    eeprom_pkg::st_waddr_lo, eeprom_pkg::st_wdata} && !start_evt && !stop_evt
    |=> sda_oe_reg)
    else $error("write byte not acknowledged");
  a_nack_ends: assert property (ack_end && state_reg == eeprom_pkg::st_read && !host_ack_reg
    && !start_evt && !stop_evt |=> state_reg == eeprom_pkg::st_idle ##1 !sda_oe_reg)
    else $error("read continued after nack");
  a_busy_holds: assert property ($rose(busy_reg) |-> busy_reg [*8])
    else $error("programming ended too early");

  c_page_write: cover property (wdata_done ##[1:1000] wdata_done);
  c_prog_done: cover property (prog_done);
  c_protect: cover property (write_stop && pins_s.wp);
  c_seq_read: cover property (host_acks);
endmodule : serial_eeprom_rw_engine
`default_nettype wire

// *** hw/eeprom_pkg.sv ***
// shared constants and types of the serial eeprom command engine
`default_nettype none
package eeprom_pkg;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int ROW_W = ADDR_W - PAGE_W;
  localparam int BYTE_W = 8;
  localparam int MEM_BYTES = 8192;
  localparam int PAGE_BYTES = 32;
  localparam int PROG_CNT_W = 24;
  localparam int STRAP_W = 3;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_MSB = 4'h7;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [PROG_CNT_W-1:0] PAGE_SLOTS = 24'h000020;
  localparam logic [PROG_CNT_W-1:0] PROG_ONE = 24'h000001;
  localparam logic [PROG_CNT_W-1:0] PROG_CYCLES_DEF = 24'h001388;
  // device type nibble: arbitrary value
  localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic [STRAP_W-1:0] strap;
  } pin_in_t;

  typedef enum {
    st_idle,
    st_dev,
    st_waddr_hi,
    st_waddr_lo,
    st_wdata,
    st_read
  } state_t;
endpackage : eeprom_pkg
`default_nettype wire

// *** hw/pin_sync.sv ***
// two flip-flop synchroniser for the pin inputs
`default_nettype none
module pin_sync (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire eeprom_pkg::pin_in_t i_pins,
  output eeprom_pkg::pin_in_t o_pins
);
  eeprom_pkg::pin_in_t meta_reg;
  eeprom_pkg::pin_in_t sync_reg;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= '{scl: 1'b1, sda: 1'b1, default: '0};
      sync_reg <= '{scl: 1'b1, sda: 1'b1, default: '0};
    end else begin
      meta_reg <= i_pins;
      sync_reg <= meta_reg;
    end
  end

  assign o_pins = sync_reg;
endmodule : pin_sync
`default_nettype wire

// *** verif/i2c_host_model.sv ***
// two-wire bus host model that drives the eeprom clock and data pins
`default_nettype none
module i2c_host_model (
  input wire logic i_clk,
  input wire logic i_dev_oe,
  input wire logic i_dev_out,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sda_host;
  // open-drain wire with pull-up: low while either side pulls it
  assign o_sda = sda_host & ~(i_dev_oe & ~i_dev_out);
  initial begin
    o_scl = 1'b1;
    sda_host = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : hold
  // scl stands high between frames; the low wait covers a device ack release
  task automatic start();
    sda_host = 1'b1;
    hold(6);
    o_scl = 1'b1;
    hold(3);
    sda_host = 1'b0;
    hold(3);
    o_scl = 1'b0;
    hold(1);
  endtask : start
  task automatic stop();
    sda_host = 1'b0;
    hold(6);
    o_scl = 1'b1;
    hold(3);
    sda_host = 1'b1;
    hold(3);
  endtask : stop
  // one bit: 6 clocks low, 2 clocks high, sampled in the high phase
  task automatic bit_io(input logic b, output logic s);
    sda_host = b;
    hold(5);
    o_scl = 1'b1;
    hold(1);
    s = o_sda;
    hold(1);
    o_scl = 1'b0;
    hold(1);
  endtask : bit_io
  // msb first; nak is the level seen in the ninth clock
  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, nak);
  endtask : send_byte
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask : recv_byte
endmodule : i2c_host_model
`default_nettype wire

// *** verif/test_serial_eeprom_rw_engine.sv ***
// self-checking bench of the serial eeprom command engine
`default_nettype none
module test_serial_eeprom_rw_engine;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [23:0] PROG_N = 24'h0000c8;
  // device type nibble: arbitrary value
  localparam logic [3:0] TYPE_ID = 4'h5;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp = 1'b0;
  logic [2:0] strap = 3'h0;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic busy;
  int n_fail = 0;
  int total_checks = 0;
  logic [7:0] mem [0:8191];
  logic [12:0] cnt;
  always #5 clk = ~clk;
  i2c_host_model host (.i_clk(clk), .i_dev_oe(sda_oe), .i_dev_out(sda_out), .o_scl(scl),
    .o_sda(sda));
  serial_eeprom_rw_engine #(.PROG_CYCLES(PROG_N), .DEV_TYPE(TYPE_ID)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda), .i_wp(wp),
    .i_strap_addr_bit2(strap[2]), .i_strap_addr_bit1(strap[1]),
    .i_strap_addr_bit0(strap[0]), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_prog_busy(busy));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // slot of the i-th data byte of a page write: low five bits wrap inside the page
  function automatic logic [12:0] page_slot(input logic [12:0] base, input int i);
    return {base[12:5], base[4:0] + 5'(i)};
  endfunction : page_slot
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  task automatic send_addr(input logic rw, output logic nak);
    host.start();
    host.send_byte({TYPE_ID, strap, rw}, nak);
  endtask : send_addr
  task automatic set_ptr(input logic [12:0] addr);
    logic nak;
    send_addr(1'b0, nak);
    chk("addr ack", 8'h00, {7'h00, nak});
    host.send_byte({3'($urandom), addr[12:8]}, nak);
    chk("hi ack", 8'h00, {7'h00, nak});
    host.send_byte(addr[7:0], nak);
    chk("lo ack", 8'h00, {7'h00, nak});
  endtask : set_ptr
  task automatic wait_ready(input logic prog);
    logic nak;
    int k;
    k = 0;
    send_addr(1'b0, nak);
    chk("first poll", {7'h00, prog}, {7'h00, nak});
    while (nak !== 1'b0 && k < 60) begin
      host.stop();
      send_addr(1'b0, nak);
      k++;
    end
    if (nak !== 1'b0) begin
      n_fail++;
      print_verdict();
    end
    chk("poll ack", 8'h00, {7'h00, nak});
    host.stop();
    host.hold(10);
    chk("dummy stop busy", 8'h00, {7'h00, busy});
  endtask : wait_ready
  task automatic wr(input logic [12:0] addr, input int n, input logic prot);
    logic nak;
    logic [7:0] d;
    wp = prot;
    set_ptr(addr);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      host.send_byte(d, nak);
      chk("data ack", 8'h00, {7'h00, nak});
      if (!prot) begin
        mem[page_slot(addr, i)] = d;
      end
    end
    host.stop();
    host.hold(10);
    chk("busy", {7'h00, ~prot}, {7'h00, busy});
    wp = ~prot;
    wait_ready(~prot);
    wp = 1'b0;
  endtask : wr
  task automatic rd(input logic [12:0] addr, input logic rnd, input int n);
    logic nak;
    logic [7:0] d;
    if (rnd) begin
      set_ptr(addr);
      cnt = addr;
    end
    send_addr(1'b1, nak);
    chk("read addr ack", 8'h00, {7'h00, nak});
    for (int i = 0; i < n; i++) begin
      host.recv_byte(i == n - 1, d);
      chk("read data", mem[cnt], d);
      cnt = cnt + 13'h0001;
    end
    host.stop();
    chk("released", 8'h00, {7'h00, sda_oe});
  endtask : rd
  initial begin
    logic nak;
    logic [12:0] a;
    int n;
    void'($urandom(74));
    strap = 3'($urandom);
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'hff;
    end
    cnt = 13'h0000;
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    host.hold(6);
    chk("oe idle", 8'h00, {7'h00, sda_oe});
    chk("busy idle", 8'h00, {7'h00, busy});
    rd(13'h0000, 1'b0, 3);
    // wrong type nibble, then each strap bit wrong
    for (int i = 0; i < 4; i++) begin
      host.start();
      host.send_byte({TYPE_ID, strap, 1'b0} ^ ((i == 0) ? 8'h80 : (8'h01 << i)), nak);
      chk("foreign addr", 8'h01, {7'h00, nak});
      host.stop();
    end
    for (int t = 0; t < 5; t++) begin
      a = 13'($urandom);
      n = (t == 0) ? 1 : ((t == 1) ? 32 : 1 + int'($urandom % 32));
      wr(a, n, t == 4);
      rd({a[12:5], 5'h00}, 1'b1, 32);
    end
    wr(13'h1ffe, 5, 1'b0);
    rd(13'h1ffe, 1'b1, 4);
    rd(13'h0000, 1'b0, 1);
    print_verdict();
  end
endmodule : test_serial_eeprom_rw_engine
`default_nettype wire
